// File: verilog/lcd_cmd_map.vh
`ifndef LCD_CMD_MAP_VH
`define LCD_CMD_MAP_VH

// Fixed-opcode commands
`define LCD_OP_FIXED_LINES 8'h90
`define LCD_OP_ALL_ON_OFF 8'hA4
`define LCD_OP_INV_OFF 8'hA6
`define LCD_OP_NIV 8'hC8
`define LCD_OP_PAT_BGR 8'hD0
`define LCD_OP_SOFT_RESET 8'hE2
`define LCD_OP_NOP 8'hE3
`define LCD_OP_WIN_MODE 8'hF8

// Reset values of the control registers
`define LCD_AC_RST 4'h1
`define LCD_FL_RST 8'h00
`define LCD_DC_RST 5'h00
`define LCD_LC_RST 8'h80
`define LCD_NIV_RST 5'h00
`define LCD_CSF_RST 3'h0

// ram_address_control fields
`define LCD_AC_WRAP 0
`define LCD_AC_ORDER 1
`define LCD_AC_RID 2
`define LCD_AC_WIN 3

// display_control fields
`define LCD_DC_INVERSE 0
`define LCD_DC_ALL_ON 1
`define LCD_DC_ENABLE 2
`define LCD_DC_GRAY 3
`define LCD_DC_GE_OFF 4

// panel_mapping_control fields
`define LCD_LC_ICON 0
`define LCD_LC_MX 1
`define LCD_LC_MY 2
`define LCD_LC_RATE_LO 3
`define LCD_LC_RATE_HI 4
`define LCD_LC_PAT 5
`define LCD_LC_MODE_LO 6
`define LCD_LC_MODE_HI 7

// Colour modes
`define LCD_MODE_4K 2'h1
`define LCD_MODE_64K 2'h2

// Address boundaries
`define LCD_COL_LAST 7'h7F
`define LCD_ROW_LAST 8'h9F

// Line rate thresholds on the mux rate
`define LCD_MUX_23 8'h6C
`define LCD_MUX_12 8'h50
`define LCD_MUX_13 8'h38
`define LCD_MUX_14 8'h28

// Power-up settle time
`define LCD_CLK_MHZ 20
`define LCD_PWR_SETTLE_US 5000
`define LCD_PWR_SETTLE_CYC (`LCD_PWR_SETTLE_US * `LCD_CLK_MHZ)

`endif

// File: verilog/lcd_cmd_decoder.v
`timescale 1ns/1ns
`include "lcd_cmd_map.vh"

module lcd_fifo
#(
  parameter WIDTH = 31,
  parameter DEPTH = 8,
  parameter AW = 3
)
(
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Fill side
  input wire inValid,
  output reg inReady_ff,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output reg outValid_ff,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;
  wire [AW:0] nxt_count;

  assign push = inValid & inReady_ff;
  assign pop = outValid_ff & outReady;
  assign nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign outData = mem[rdPtr_ff];

  always @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      inReady_ff <= 1'b1;
      outValid_ff <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr_ff <= wrPtr_ff + 1'b1;
      if (pop)
        rdPtr_ff <= rdPtr_ff + 1'b1;
      count_ff <= nxt_count;
      inReady_ff <= (nxt_count != DEPTH[AW:0]);
      outValid_ff <= (nxt_count != {(AW+1){1'b0}});
    end
  end
endmodule

module lcd_cmd_decoder
#(
  parameter PWR_SETTLE_CYC = `LCD_PWR_SETTLE_CYC
)
(
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Host bus
  input wire wrStb,
  input wire cmdSel,
  input wire busWide,
  input wire [15:0] dataIn,
  output wire hostReady,
  // Display RAM write port
  output reg ramWrEn_ff,
  input wire ramReady,
  output reg [6:0] ramCol_ff,
  output reg [7:0] ramRow_ff,
  output reg [15:0] ramData_ff,
  // Control registers
  output reg [3:0] ramAddressControl_ff,
  output reg [7:0] fixedLinesSetting_ff,
  output reg [4:0] displayControl_ff,
  output reg [7:0] panelMappingControl_ff,
  output reg [4:0] lineInversionSetup_ff,
  output reg [2:0] commonScanOptions_ff,
  output reg [6:0] columnPointer_ff,
  output reg [7:0] rowPointer_ff,
  // Derived display settings
  input wire [7:0] muxRate,
  output reg [9:0] lineRate_ff,
  output reg [4:0] fixedTopRows_ff,
  output reg [4:0] fixedBottomRows_ff,
  output reg powerOn_ff,
  output reg driversOn_ff
);
  localparam PEND_NONE = 2'h0;
  localparam PEND_FIX = 2'h1;
  localparam PEND_NIV = 2'h2;
  localparam PEND_SKIP = 2'h3;
  localparam PS_SLEEP = 2'h0;
  localparam PS_RAMP = 2'h1;
  localparam PS_ACTIVE = 2'h2;

  reg [1:0] pendOp_ff;
  reg [1:0] pendCnt_ff;
  reg [1:0] bytePhase_ff;
  reg [11:0] hold_ff;
  reg [1:0] pwrState_ff;
  reg [16:0] pwrCnt_ff;
  reg [1:0] nxt_bytePhase;
  reg [11:0] nxt_hold;
  reg pixPush;
  reg [15:0] pixData;
  reg [6:0] nxt_col;
  reg [7:0] nxt_row;
  reg [9:0] baseRate;
  reg [9:0] nxt_lineRate;
  wire [7:0] op;
  wire cmdWr;
  wire dataWr;
  wire fifoReady;
  wire fifoOutValid;
  wire fifoOutReady;
  wire [30:0] fifoOut;
  wire wideMode4k;
  wire geOn;
  wire [6:0] storeCol;
  wire dispEn;

  assign op = dataIn[7:0];
  assign cmdWr = wrStb & ~cmdSel;
  // Pixel writes while the buffer is full are dropped; host must watch ready
  assign dataWr = wrStb & cmdSel & fifoReady;
  assign hostReady = fifoReady;
  assign wideMode4k = (panelMappingControl_ff[7:6] == `LCD_MODE_4K);
  assign geOn = ~displayControl_ff[`LCD_DC_GE_OFF];
  assign dispEn = displayControl_ff[`LCD_DC_ENABLE];
  assign storeCol = panelMappingControl_ff[`LCD_LC_MX] ?
    (`LCD_COL_LAST - columnPointer_ff) : columnPointer_ff;
  assign fifoOutReady = ~ramWrEn_ff | ramReady;

  // Widen 12-bit input to 5-6-5 by repeating top bits
  function [15:0] widen;
    input [11:0] x;
    input ge;
    begin
      if (ge)
        widen = {x[11:8], x[11], x[7:3], x[7], x[2:0], x[2:1]};
      else
        widen = {x[11:8], x[11], x[7:4], x[7:6], x[3:0], x[3]};
    end
  endfunction

  always @*
  begin
    nxt_bytePhase = bytePhase_ff;
    nxt_hold = hold_ff;
    pixPush = 1'b0;
    pixData = 16'h0000;
    if (dataWr)
    begin
      if (busWide)
      begin
        pixPush = 1'b1;
        pixData = wideMode4k ? widen(dataIn[11:0], geOn) : dataIn;
      end
      else if (wideMode4k)
      begin
        case (bytePhase_ff)
          2'h0:
          begin
            nxt_hold = {4'h0, op};
            nxt_bytePhase = 2'h1;
          end
          2'h1:
          begin
            pixPush = 1'b1;
            pixData = widen({hold_ff[7:0], op[7:4]}, geOn);
            nxt_hold = {8'h00, op[3:0]};
            nxt_bytePhase = 2'h2;
          end
          default:
          begin
            pixPush = 1'b1;
            pixData = widen({hold_ff[3:0], op}, geOn);
            nxt_bytePhase = 2'h0;
          end
        endcase
      end
      else
      begin
        if (bytePhase_ff == 2'h0)
        begin
          nxt_hold = {4'h0, op};
          nxt_bytePhase = 2'h1;
        end
        else
        begin
          pixPush = 1'b1;
          pixData = {hold_ff[7:0], op};
          nxt_bytePhase = 2'h0;
        end
      end
    end
  end

  // Pointer stepping; window bounds stay at full map so window mode is moot
  always @*
  begin
    nxt_col = columnPointer_ff;
    nxt_row = rowPointer_ff;
    if (!ramAddressControl_ff[`LCD_AC_ORDER])
    begin
      if (columnPointer_ff != `LCD_COL_LAST)
        nxt_col = columnPointer_ff + 7'h01;
      else if (ramAddressControl_ff[`LCD_AC_WRAP])
      begin
        nxt_col = 7'h00;
        if (ramAddressControl_ff[`LCD_AC_RID])
          nxt_row = (rowPointer_ff == 8'h00) ? `LCD_ROW_LAST :
            rowPointer_ff - 8'h01;
        else
          nxt_row = (rowPointer_ff == `LCD_ROW_LAST) ? 8'h00 :
            rowPointer_ff + 8'h01;
      end
    end
    else
    begin
      if (ramAddressControl_ff[`LCD_AC_RID])
      begin
        if (rowPointer_ff != 8'h00)
          nxt_row = rowPointer_ff - 8'h01;
        else if (ramAddressControl_ff[`LCD_AC_WRAP])
        begin
          nxt_row = `LCD_ROW_LAST;
          nxt_col = columnPointer_ff + 7'h01;
        end
      end
      else
      begin
        if (rowPointer_ff != `LCD_ROW_LAST)
          nxt_row = rowPointer_ff + 8'h01;
        else if (ramAddressControl_ff[`LCD_AC_WRAP])
        begin
          nxt_row = 8'h00;
          nxt_col = columnPointer_ff + 7'h01;
        end
      end
    end
  end

  // Line rate in units of 0.1 klines/s
  always @*
  begin
    case ({displayControl_ff[`LCD_DC_GRAY],
      panelMappingControl_ff[`LCD_LC_RATE_HI:`LCD_LC_RATE_LO]})
      3'h0: baseRate = 10'd85;
      3'h1: baseRate = 10'd104;
      3'h2: baseRate = 10'd126;
      3'h3: baseRate = 10'd152;
      3'h4: baseRate = 10'd252;
      3'h5: baseRate = 10'd305;
      3'h6: baseRate = 10'd370;
      default: baseRate = 10'd448;
    endcase
    if (muxRate <= `LCD_MUX_14)
      nxt_lineRate = {2'b00, baseRate[9:2]};
    else if (muxRate <= `LCD_MUX_13)
      nxt_lineRate = baseRate / 10'd3;
    else if (muxRate <= `LCD_MUX_12)
      nxt_lineRate = {1'b0, baseRate[9:1]};
    else if (muxRate <= `LCD_MUX_23)
      nxt_lineRate = {baseRate[8:0], 1'b0} / 10'd3;
    else
      nxt_lineRate = baseRate;
  end

  lcd_fifo #(.WIDTH(31), .DEPTH(8), .AW(3)) pixFifo
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .inValid(pixPush),
    .inReady_ff(fifoReady),
    .inData({storeCol, rowPointer_ff, pixData}),
    .outValid_ff(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  // Control registers, command decoding and byte phase
  always @(posedge sys_clk)
  begin
    if (!rstn || (cmdWr && pendOp_ff == PEND_NONE &&
      op == `LCD_OP_SOFT_RESET))
    begin
      ramAddressControl_ff <= `LCD_AC_RST;
      fixedLinesSetting_ff <= `LCD_FL_RST;
      displayControl_ff <= `LCD_DC_RST;
      panelMappingControl_ff <= `LCD_LC_RST;
      lineInversionSetup_ff <= `LCD_NIV_RST;
      commonScanOptions_ff <= `LCD_CSF_RST;
      pendOp_ff <= PEND_NONE;
      pendCnt_ff <= 2'h0;
      bytePhase_ff <= 2'h0;
    end
    else
    begin
      bytePhase_ff <= nxt_bytePhase;
      if (cmdWr)
        bytePhase_ff <= 2'h0;
      if (cmdWr && pendOp_ff != PEND_NONE)
      begin
        if (pendOp_ff == PEND_FIX)
          fixedLinesSetting_ff <= op;
        if (pendOp_ff == PEND_NIV)
          lineInversionSetup_ff <= op[4:0];
        if (pendCnt_ff == 2'h0)
          pendOp_ff <= PEND_NONE;
        else
          pendCnt_ff <= pendCnt_ff - 2'h1;
      end
      else if (cmdWr)
      begin
        casez (op)
          `LCD_OP_FIXED_LINES: pendOp_ff <= PEND_FIX;
          `LCD_OP_NIV: pendOp_ff <= PEND_NIV;
          8'b1000_1???:
            ramAddressControl_ff[2:0] <= op[2:0];
          8'b1010_00??:
            panelMappingControl_ff[4:3] <= op[1:0];
          8'b1010_010?:
            displayControl_ff[`LCD_DC_ALL_ON] <= op[0];
          8'b1010_011?:
            displayControl_ff[`LCD_DC_INVERSE] <= op[0];
          8'b1010_1???:
            displayControl_ff[4:2] <= op[2:0];
          8'b1100_0???:
            panelMappingControl_ff[2:0] <= op[2:0];
          8'b1101_000?:
            panelMappingControl_ff[`LCD_LC_PAT] <= op[0];
          8'b1101_01??:
            panelMappingControl_ff[7:6] <= op[1:0];
          8'b1101_1???:
            commonScanOptions_ff <= op[2:0];
          8'b1111_100?:
            ramAddressControl_ff[`LCD_AC_WIN] <= op[0];
          8'b0011_000?, 8'h81, 8'b1110_01??, 8'hB8,
          8'hF1, 8'hF2, 8'hF3, 8'b1111_01??:
          begin
            pendOp_ff <= PEND_SKIP;
            pendCnt_ff <= 2'h0;
          end
          8'hB9:
          begin
            pendOp_ff <= PEND_SKIP;
            pendCnt_ff <= 2'h1;
          end
          default:
          begin
            // NOP and unsupported opcodes leave all control registers alone
          end
        endcase
      end
    end
  end

  // Pointers and the held byte survive soft reset
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      columnPointer_ff <= 7'h00;
      rowPointer_ff <= 8'h00;
      hold_ff <= 12'h000;
    end
    else
    begin
      hold_ff <= nxt_hold;
      if (pixPush)
      begin
        columnPointer_ff <= nxt_col;
        rowPointer_ff <= nxt_row;
      end
      else if (cmdWr && pendOp_ff == PEND_NONE)
      begin
        casez (op)
          8'b0000_????: columnPointer_ff[3:0] <= op[3:0];
          8'b0001_0???: columnPointer_ff[6:4] <= op[2:0];
          8'b0110_????: rowPointer_ff[3:0] <= op[3:0];
          8'b0111_????: rowPointer_ff[7:4] <= op[3:0];
          default: rowPointer_ff <= rowPointer_ff;
        endcase
      end
    end
  end

  // RAM write stage and derived settings
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ramWrEn_ff <= 1'b0;
      ramCol_ff <= 7'h00;
      ramRow_ff <= 8'h00;
      ramData_ff <= 16'h0000;
      lineRate_ff <= 10'h000;
      fixedTopRows_ff <= 5'h00;
      fixedBottomRows_ff <= 5'h00;
    end
    else
    begin
      if (fifoOutValid && fifoOutReady)
      begin
        ramWrEn_ff <= 1'b1;
        ramCol_ff <= fifoOut[30:24];
        ramRow_ff <= fifoOut[23:16];
        ramData_ff <= fifoOut[15:0];
      end
      else if (ramReady)
        ramWrEn_ff <= 1'b0;
      lineRate_ff <= nxt_lineRate;
      if (panelMappingControl_ff[`LCD_LC_MY])
      begin
        fixedTopRows_ff <= {fixedLinesSetting_ff[3:0], 1'b0};
        fixedBottomRows_ff <= {fixedLinesSetting_ff[7:4], 1'b0};
      end
      else
      begin
        fixedTopRows_ff <= {fixedLinesSetting_ff[7:4], 1'b0};
        fixedBottomRows_ff <= {fixedLinesSetting_ff[3:0], 1'b0};
      end
    end
  end

  // Sleep exit: power first, drivers after the supply settles
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pwrState_ff <= PS_SLEEP;
      pwrCnt_ff <= 17'h00000;
      powerOn_ff <= 1'b0;
      driversOn_ff <= 1'b0;
    end
    else if (!dispEn)
    begin
      pwrState_ff <= PS_SLEEP;
      pwrCnt_ff <= 17'h00000;
      powerOn_ff <= 1'b0;
      driversOn_ff <= 1'b0;
    end
    else
    begin
      case (pwrState_ff)
        PS_SLEEP:
        begin
          pwrState_ff <= PS_RAMP;
          powerOn_ff <= 1'b1;
          pwrCnt_ff <= 17'h00000;
        end
        PS_RAMP:
        begin
          if (pwrCnt_ff >= PWR_SETTLE_CYC[16:0] - 17'h00001)
          begin
            pwrState_ff <= PS_ACTIVE;
            driversOn_ff <= 1'b1;
          end
          else
            pwrCnt_ff <= pwrCnt_ff + 17'h00001;
        end
        PS_ACTIVE: driversOn_ff <= 1'b1;
        default: pwrState_ff <= PS_SLEEP;
      endcase
    end
  end
endmodule

// File: tb/lcd_cmd_checker.sv
`timescale 1ns/1ns
module lcd_cmd_checker (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Host bus
  input wire wrStb,
  input wire cmdSel,
  input wire [15:0] dataIn,
  // RAM port
  input wire ramWrEn_ff,
  input wire ramReady,
  input wire [6:0] ramCol_ff,
  input wire [7:0] ramRow_ff,
  input wire [15:0] ramData_ff,
  // Control state
  input wire [3:0] ramAddressControl_ff,
  input wire [7:0] fixedLinesSetting_ff,
  input wire [4:0] displayControl_ff,
  input wire [7:0] panelMappingControl_ff,
  input wire [4:0] lineInversionSetup_ff,
  input wire [2:0] commonScanOptions_ff,
  input wire [4:0] fixedTopRows_ff,
  input wire [4:0] fixedBottomRows_ff,
  input wire powerOn_ff,
  input wire driversOn_ff
);
  // Two NOPs in a row make sure the next command byte is an opcode
  reg [7:0] lastCmd_ff, prevCmd_ff;
  wire opOk;
  wire [7:0] op;
  assign op = dataIn[7:0];
  assign opOk = wrStb && !cmdSel && lastCmd_ff == 8'hE3 && prevCmd_ff == 8'hE3;
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      lastCmd_ff <= 8'h00;
      prevCmd_ff <= 8'h00;
    end
    else if (wrStb && !cmdSel)
    begin
      prevCmd_ff <= lastCmd_ff;
      lastCmd_ff <= op;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_ram_hold;
    ramWrEn_ff && !ramReady |=> ramWrEn_ff && $stable(ramCol_ff)
      && $stable(ramRow_ff) && $stable(ramData_ff);
  endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("RAM hold");
  property p_all_on;
    opOk && op[7:1] == 7'h52 |=> displayControl_ff[1] == $past(op[0]);
  endproperty
  a_all_on: assert property (p_all_on) else $error("all-on bit");
  property p_inverse;
    opOk && op[7:1] == 7'h53 |=> displayControl_ff[0] == $past(op[0]);
  endproperty
  a_inverse: assert property (p_inverse) else $error("inverse bit");
  property p_display;
    opOk && op[7:3] == 5'h15 |=> displayControl_ff[4:2] == $past(op[2:0]);
  endproperty
  a_display: assert property (p_display) else $error("display bits");
  property p_mapping;
    opOk && op[7:3] == 5'h18 |=> panelMappingControl_ff[2:0] == $past(op[2:0]);
  endproperty
  a_mapping: assert property (p_mapping) else $error("mapping bits");
  property p_pattern;
    opOk && op[7:1] == 7'h68 |=> panelMappingControl_ff[5] == $past(op[0]);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern bit");
  property p_scan;
    opOk && op[7:3] == 5'h1B |=> commonScanOptions_ff == $past(op[2:0]);
  endproperty
  a_scan: assert property (p_scan) else $error("scan bits");
  property p_addr;
    opOk && op[7:3] == 5'h11 |=> ramAddressControl_ff[2:0] == $past(op[2:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("address bits");
  property p_fixed;
    opOk && op == 8'h90 ##1 wrStb && !cmdSel |=>
      fixedLinesSetting_ff == $past(op);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed lines");
  property p_niv;
    opOk && op == 8'hC8 ##1 wrStb && !cmdSel |=>
      lineInversionSetup_ff == $past(op[4:0]);
  endproperty
  a_niv: assert property (p_niv) else $error("line inversion");
  property p_soft;
    opOk && op == 8'hE2 |=> ramAddressControl_ff == 4'h1
      && fixedLinesSetting_ff == 8'h00 && displayControl_ff == 5'h00
      && panelMappingControl_ff == 8'h80 && lineInversionSetup_ff == 5'h00
      && commonScanOptions_ff == 3'h0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
  property p_rows;
    ($stable(fixedLinesSetting_ff) && $stable(panelMappingControl_ff))[*2]
      |-> {fixedTopRows_ff, fixedBottomRows_ff} == (panelMappingControl_ff[2]
      ? {fixedLinesSetting_ff[3:0], 1'b0, fixedLinesSetting_ff[7:4], 1'b0}
      : {fixedLinesSetting_ff[7:4], 1'b0, fixedLinesSetting_ff[3:0], 1'b0});
  endproperty
  a_rows: assert property (p_rows) else $error("fixed rows");
  property p_drivers;
    driversOn_ff |-> powerOn_ff && $past(displayControl_ff[2]);
  endproperty
  a_drivers: assert property (p_drivers) else $error("driver order");
endmodule
bind lcd_cmd_decoder lcd_cmd_checker chk (.sys_clk, .rstn, .wrStb, .cmdSel,
  .dataIn, .ramWrEn_ff, .ramReady, .ramCol_ff, .ramRow_ff, .ramData_ff,
  .ramAddressControl_ff, .fixedLinesSetting_ff, .displayControl_ff,
  .panelMappingControl_ff, .lineInversionSetup_ff, .commonScanOptions_ff,
  .fixedTopRows_ff, .fixedBottomRows_ff, .powerOn_ff, .driversOn_ff);

// File: tb/lcd_ram_model.sv
`timescale 1ns/1ns
module lcd_ram_model (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Pacing from the bench
  input wire stall,
  input wire slow,
  // Write port
  input wire wrReq,
  input wire [6:0] wrCol,
  input wire [7:0] wrRow,
  input wire [15:0] wrData,
  output wire wrAck
);
  // Slow mode accepts on alternate cycles only
  reg tog_ff;
  reg [30:0] mem [0:63];
  integer wCnt_ff;
  assign wrAck = !stall && (!slow || tog_ff);
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      tog_ff <= 1'b0;
      wCnt_ff <= 0;
    end
    else
    begin
      tog_ff <= !tog_ff;
      if (wrReq && wrAck)
      begin
        mem[wCnt_ff] <= {wrCol, wrRow, wrData};
        wCnt_ff <= wCnt_ff + 1;
      end
    end
  end
endmodule

// File: tb/lcd_control_command_decoder_tb_top.sv
`timescale 1ns/1ns
module lcd_control_command_decoder_tb_top;
  reg sys_clk, rstn, wrStb, cmdSel, busWide, stall, slow;
  reg [15:0] dataIn;
  reg [7:0] muxRate;
  wire hostReady, ramWrEn, ramReady, powerOn, driversOn;
  wire [6:0] ramCol, colPtr;
  wire [7:0] ramRow, fl, lc, rowPtr;
  wire [15:0] ramData;
  wire [3:0] ac;
  wire [4:0] dc, line_inversion_setup, topRows, botRows;
  wire [2:0] common_scan_options;
  wire [9:0] lineRate;
  integer n_mismatch, n_tests, sentIdx, chkIdx, k;
  lcd_cmd_decoder #(.PWR_SETTLE_CYC(8)) uut (.sys_clk, .rstn, .wrStb,
    .cmdSel, .busWide, .dataIn, .hostReady, .ramWrEn_ff(ramWrEn),
    .ramReady, .ramCol_ff(ramCol), .ramRow_ff(ramRow), .ramData_ff(ramData),
    .ramAddressControl_ff(ac), .fixedLinesSetting_ff(fl),
    .displayControl_ff(dc), .panelMappingControl_ff(lc),
    .lineInversionSetup_ff(line_inversion_setup), .commonScanOptions_ff(common_scan_options),
    .columnPointer_ff(colPtr), .rowPointer_ff(rowPtr), .muxRate,
    .lineRate_ff(lineRate), .fixedTopRows_ff(topRows),
    .fixedBottomRows_ff(botRows), .powerOn_ff(powerOn),
    .driversOn_ff(driversOn));
  lcd_ram_model ram (.sys_clk, .rstn, .stall, .slow, .wrReq(ramWrEn),
    .wrCol(ramCol), .wrRow(ramRow), .wrData(ramData), .wrAck(ramReady));
  function [15:0] pd(input integer i);
    pd = 16'h8421 * i + 16'h1357;
  endfunction
  function [15:0] e444(input [11:0] x);
    e444 = {x[11:8], x[11], x[7:4], x[7:6], x[3:0], x[3]};
  endfunction
  function [15:0] e453(input [11:0] x);
    e453 = {x[11:8], x[11], x[7:3], x[7], x[2:0], x[2:1]};
  endfunction
  task print_verdict;
  begin
    $display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task check(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  // Strobe stays up between calls so bytes go back to back
  task wr(input c, input [15:0] d);
  begin
    wrStb <= 1'b1;
    cmdSel <= c;
    dataIn <= d;
    @(posedge sys_clk);
  end
  endtask
  task idle(input integer n);
  begin
    wrStb <= 1'b0;
    repeat (n) @(posedge sys_clk);
  end
  endtask
  // Leading NOPs keep the opcode phase known; upper byte must be ignored
  task op(input [7:0] x);
  begin
    wr(1'b0, 16'h00E3);
    wr(1'b0, 16'h00E3);
    wr(1'b0, {8'h5A, x});
  end
  endtask
  task setPtr(input [6:0] c, input [7:0] r);
  begin
    op({4'h0, c[3:0]});
    op({5'h02, c[6:4]});
    op({4'h6, r[3:0]});
    op({4'h7, r[7:4]});
  end
  endtask
  task burst(input integer n);
    reg [15:0] d;
    integer i;
  begin
    for (i = 0; i < n; i = i + 1)
    begin
      d = pd(sentIdx);
      sentIdx = sentIdx + 1;
      if (busWide)
        wr(1'b1, d);
      else
      begin
        wr(1'b1, {8'h00, d[15:8]});
        wr(1'b1, {8'h00, d[7:0]});
      end
    end
    idle(1);
  end
  endtask
  task waitW(input integer n);
    integer i;
  begin
    for (i = 0; i < 300 && ram.wCnt_ff < n; i = i + 1)
      @(posedge sys_clk);
    if (ram.wCnt_ff < n)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: RAM write timeout", $time);
      print_verdict;
    end
  end
  endtask
  task expPix(input [6:0] c, input [7:0] r);
  begin
    waitW(chkIdx + 1);
    check(ram.mem[chkIdx], {c, r, pd(chkIdx)});
    chkIdx = chkIdx + 1;
  end
  endtask
  task rate(input [7:0] m, input [9:0] e);
  begin
    muxRate <= m;
    idle(4);
    check(lineRate, e);
  end
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    sentIdx = 0;
    chkIdx = 0;
    rstn = 1'b0;
    wrStb = 1'b0;
    cmdSel = 1'b0;
    busWide = 1'b0;
    dataIn = 16'h0000;
    muxRate = 8'hA0;
    stall = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    check({ac, fl, dc}, {4'h1, 8'h00, 5'h00});
    check({lc, line_inversion_setup, common_scan_options, hostReady}, {8'h80, 5'h00, 3'h0, 1'b1});
    op(8'h90);
    wr(1'b0, 16'h00E2);
    idle(3);
    check(fl, 8'hE2);
    check(ac, 4'h1);
    check({topRows, botRows}, {5'h1C, 5'h04});
    op(8'hC4);
    idle(3);
    check({topRows, botRows, lc}, {5'h04, 5'h1C, 8'h84});
    op(8'hC8);
    wr(1'b0, 16'hFF1D);
    idle(3);
    check(line_inversion_setup, 5'h1D);
    op(8'hA5);
    op(8'hA7);
    idle(3);
    check(dc[1:0], 2'h3);
    op(8'hA4);
    op(8'hA6);
    idle(3);
    check(dc[1:0], 2'h0);
    for (k = 0; k < 8; k = k + 1)
    begin
      op({5'h1B, k[2:0]});
      op({5'h18, k[2:0]});
      op({5'h11, k[2:0]});
      idle(3);
      check({common_scan_options, lc[2:0], ac[2:0]}, {3{k[2:0]}});
    end
    op(8'hD1);
    idle(3);
    check(lc[5], 1'b1);
    op(8'hAA);
    op(8'hA3);
    rate(8'hA0, 10'h1C0);
    rate(8'h6C, 10'h12A);
    rate(8'h50, 10'h0E0);
    rate(8'h38, 10'h095);
    rate(8'h28, 10'h070);
    op(8'hA8);
    op(8'hA0);
    rate(8'hA0, 10'h055);
    op(8'hA9);
    idle(14);
    check({powerOn, driversOn}, 2'h3);
    op(8'hA8);
    idle(4);
    check({powerOn, driversOn}, 2'h0);
    op(8'h89);
    // Partial display is never entered, so the icon bit needs no guard
    op(8'hC0);
    setPtr(7'h7E, 8'h05);
    burst(3);
    expPix(7'h7E, 8'h05);
    expPix(7'h7F, 8'h05);
    expPix(7'h00, 8'h06);
    op(8'h8D);
    busWide <= 1'b1;
    slow <= 1'b1;
    setPtr(7'h7F, 8'h05);
    burst(2);
    expPix(7'h7F, 8'h05);
    expPix(7'h00, 8'h04);
    op(8'h88);
    setPtr(7'h7E, 8'h09);
    burst(3);
    expPix(7'h7E, 8'h09);
    expPix(7'h7F, 8'h09);
    expPix(7'h7F, 8'h09);
    op(8'h8B);
    setPtr(7'h03, 8'h9F);
    burst(2);
    expPix(7'h03, 8'h9F);
    expPix(7'h04, 8'h00);
    op(8'h89);
    op(8'hF9);
    op(8'hC2);
    setPtr(7'h7F, 8'h07);
    burst(2);
    expPix(7'h00, 8'h07);
    expPix(7'h7F, 8'h08);
    op(8'hC0);
    slow <= 1'b0;
    stall <= 1'b1;
    setPtr(7'h00, 8'h14);
    burst(10);
    check(hostReady, 1'b0);
    // Eight words fill the buffer, one more waits at the RAM port
    sentIdx = sentIdx - 1;
    stall <= 1'b0;
    for (k = 0; k < 9; k = k + 1)
      expPix(k[6:0], 8'h14);
    idle(10);
    check(ram.wCnt_ff, sentIdx);
    check(colPtr, 7'h09);
    op(8'hE2);
    idle(3);
    check({ac, fl, dc}, {4'h1, 8'h00, 5'h00});
    check({lc, line_inversion_setup, common_scan_options}, {8'h80, 5'h00, 3'h0});
    check({colPtr, rowPtr}, {7'h09, 8'h14});
    op(8'hAC);
    op(8'hD5);
    busWide <= 1'b0;
    setPtr(7'h28, 8'h1E);
    wr(1'b1, 16'h0012);
    wr(1'b1, 16'h0034);
    wr(1'b1, 16'h0056);
    idle(1);
    waitW(chkIdx + 2);
    check(ram.mem[chkIdx], {7'h28, 8'h1E, e444(12'h123)});
    check(ram.mem[chkIdx + 1], {7'h29, 8'h1E, e444(12'h456)});
    chkIdx = chkIdx + 2;
    op(8'hA8);
    busWide <= 1'b1;
    wr(1'b1, 16'hF5A7);
    idle(1);
    waitW(chkIdx + 1);
    check(ram.mem[chkIdx], {7'h2A, 8'h1E, e453(12'h5A7)});
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(2);
    check({ac, dc, lc, colPtr}, {4'h1, 5'h00, 8'h80, 7'h00});
    print_verdict;
  end
endmodule
